// ==== rtl/dsr_bank.sv ====
/*
  Read-only diagnostic status bank with stage lock and answer window mirror.
  Assumes decoded read requests, status inputs on the same clock,
  and key and reset pins that arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_bank (
  input wire logic clock,
  input wire logic rst,
  input wire dsr_pkg::dsr_status_t status,
  input wire logic keyPin,
  input wire logic keyAboveHigh,
  input wire logic keyBelowLow,
  input wire logic resetPinN,
  input wire logic softwareResetCommand,
  input wire logic startCmd,
  input wire dsr_pkg::dsr_read_req_t readReq,
  input wire logic writeReq,
  input wire logic [7:0] writeSub,
  input wire logic answerWindowWrite,
  input wire logic [5:0] answerWindowLength,
  input wire dsr_pkg::dsr_stage_cmd_t stageCmdIn,
  output dsr_pkg::dsr_read_ans_t readAns,
  output dsr_pkg::dsr_stage_cmd_t stageCmdOut,
  output logic stagesLockedFlag,
  output logic [2:0] errorCount,
  output logic [5:0] answerWindowMirror
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic keyFiltered;
  logic keyHigh;
  logic keyLow;
  logic resetPinLevelN;

  dsr_sync #(.W(3), .INIT(3'h0)) u_keySync (
    .clock(clock),
    .rst(rst),
    .din({keyPin, keyAboveHigh, keyBelowLow}),
    .dout({keyFiltered, keyHigh, keyLow})
  );

  // The pin starts out released so that the synchroniser adds no lock of its own
  // to the one that the core reset already applies.
  dsr_sync #(.W(1), .INIT(1'b1)) u_rstPinSync (
    .clock(clock),
    .rst(rst),
    .din(resetPinN),
    .dout(resetPinLevelN)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Encoders.

  function automatic logic [1:0] encodeNormal(input dsr_pkg::dsr_stage_fault_t f);
    logic [1:0] c;
    c = dsr_pkg::CODE_OK;
    if (f.toGround) begin
      c = dsr_pkg::CODE_SHORT_LOW;
    end else if (f.toSupply) begin
      c = dsr_pkg::CODE_SHORT_HIGH;
    end else if (f.open) begin
      c = dsr_pkg::CODE_OPEN;
    end
    return c;
  endfunction : encodeNormal

  function automatic logic [1:0] encodeSwapped(input dsr_pkg::dsr_stage_fault_t f);
    logic [1:0] c;
    c = dsr_pkg::CODE_OK;
    if (f.toSupply) begin
      c = dsr_pkg::CODE_SHORT_LOW;
    end else if (f.toGround) begin
      c = dsr_pkg::CODE_SHORT_HIGH;
    end else if (f.open) begin
      c = dsr_pkg::CODE_OPEN;
    end
    return c;
  endfunction : encodeSwapped

  function automatic logic [7:0] encodeBridge(input dsr_pkg::dsr_bridge_state_t b);
    logic [7:0] c;
    c = dsr_pkg::HB_OK;
    if (b.gndShortOff) begin
      c = dsr_pkg::HB_GND_OFF;
    end else if (b.supShortOff) begin
      c = dsr_pkg::HB_SUP_OFF;
    end else if (b.openOff) begin
      c = dsr_pkg::HB_OPEN_OFF;
    end else if (b.openOn) begin
      c = dsr_pkg::HB_OPEN_ON;
    end else if (b.overcurOn) begin
      c = dsr_pkg::HB_OVC_ON;
    end else if (b.detectRunning) begin
      c = dsr_pkg::HB_RUNNING;
    end
    return c;
  endfunction : encodeBridge

  // Overload hides a simultaneous overvoltage or overtemperature.
  function automatic logic [1:0] encodeSupply(input logic overload, input logic ovOt);
    logic [1:0] c;
    c = dsr_pkg::CODE_OK;
    if (overload) begin
      c = dsr_pkg::SUPPLY_OVERLOAD;
    end else if (ovOt) begin
      c = dsr_pkg::SUPPLY_OV_OT;
    end
    return c;
  endfunction : encodeSupply

  ////////////////////////////////////////////////////////////////////////////
  // Sticky fault capture.

  dsr_pkg::dsr_sticky_t stickySet;
  dsr_pkg::dsr_sticky_t stickyClr;
  dsr_pkg::dsr_sticky_t sticky;
  logic readHit;
  logic anySparkFault;
  logic anyBridgeFault;

  assign readHit = readReq.valid;

  always_comb begin
    anySparkFault = 1'b0;
    anyBridgeFault = 1'b0;
    for (int i = 0; i < 4; i++) begin
      anySparkFault = anySparkFault | (|status.spark[i]);
      anyBridgeFault = anyBridgeFault | (|status.bridgeOut[i]);
    end
    anyBridgeFault = anyBridgeFault | status.bridge.gndShortOff | status.bridge.supShortOff;
    anyBridgeFault = anyBridgeFault | status.bridge.openOff | status.bridge.openOn;
    anyBridgeFault = anyBridgeFault | status.bridge.overcurOn;
  end

  always_comb begin
    stickySet.bridgeOut = status.bridgeOut;
    stickySet.bridge = status.bridge;
    stickySet.spark = status.spark;
    stickySet.reluctanceFault = status.reluctanceFault;
    stickySet.trackOverload = status.trackOverload;
    stickySet.trackOvOt = status.trackOvOt;
    stickySet.tunnelReset = status.tunnelReset;
    stickySet.shortUndervoltageReset = status.shortUndervoltageReset;
    stickySet.mainSummary = status.mainStageFault | anySparkFault;
    stickySet.bridgeSummary = anyBridgeFault;
    stickySet.logicRailOvervoltage = status.logicRailOvervoltage;
    stickySet.lowRailUndervoltage = status.lowRailUndervoltage;
    stickySet.batteryOvervoltageShutoff = status.batteryOvervoltageShutoff;
    stickySet.overtemp = status.overtemp;
    stickySet.longUndervoltageReset = status.longUndervoltageReset;
    stickySet.transceiverErr = |status.transceiverErr;
    stickySet.monitorResetSticky = status.monitorReset;
    stickySet.seoInjector = status.seoInjector;
    stickySet.seoRelay = status.seoRelay;
  end

  // Each register clears its own fault bits, and a clearing read of any register drops the monitor flag; writes never clear anything.
  always_comb begin
    stickyClr = '0;
    if (readHit) begin
      unique case (readReq.sub)
        dsr_pkg::SUB_BRIDGE_TWO: begin
          stickyClr.bridgeOut = '1;
          stickyClr.bridge = '1;
        end
        dsr_pkg::SUB_IGNITION: begin
          stickyClr.spark = '1;
        end
        dsr_pkg::SUB_SUPPLY: begin
          stickyClr.reluctanceFault = 1'b1;
          stickyClr.trackOverload = '1;
          stickyClr.trackOvOt = '1;
        end
        dsr_pkg::SUB_RESET_CAUSE: begin
          stickyClr.tunnelReset = 1'b1;
          stickyClr.shortUndervoltageReset = 1'b1;
          stickyClr.mainSummary = 1'b1;
          stickyClr.bridgeSummary = 1'b1;
          stickyClr.logicRailOvervoltage = 1'b1;
          stickyClr.lowRailUndervoltage = 1'b1;
          stickyClr.batteryOvervoltageShutoff = 1'b1;
        end
        dsr_pkg::SUB_OVERTEMP: begin
          stickyClr.overtemp = '1;
          stickyClr.longUndervoltageReset = 1'b1;
          stickyClr.transceiverErr = 1'b1;
        end
        dsr_pkg::SUB_SAFETY: begin
          stickyClr.seoInjector = 1'b1;
          stickyClr.seoRelay = 1'b1;
        end
        default: begin
          stickyClr = '0;
        end
      endcase
      // Only the clearing read command drops the sticky monitor flag.
      stickyClr.monitorResetSticky = (readReq.cmd == dsr_pkg::CMD_READ_CLEAR_MON);
    end
  end

  dsr_sticky #(.W($bits(dsr_pkg::dsr_sticky_t))) u_sticky (
    .clock(clock),
    .rst(rst),
    .setIn(stickySet),
    .clrIn(stickyClr),
    .flags(sticky)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Key hysteresis and stage lock.

  logic keyHyst_q;
  logic locked_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      keyHyst_q <= 1'b0;
    end else if (keyHigh) begin
      keyHyst_q <= 1'b1;
    end else if (keyLow) begin
      keyHyst_q <= 1'b0;
    end
  end

  // Any reset source beats a start command in the same cycle, so a lock
  // can never be lost while the synchronised reset pin level is still low.
  always_ff @(posedge clock) begin
    if (rst) begin
      locked_q <= 1'b1;
    end else if (softwareResetCommand || !resetPinLevelN) begin
      locked_q <= 1'b1;
    end else if (startCmd) begin
      locked_q <= 1'b0;
    end
  end

  dsr_pkg::dsr_stage_cmd_t stageCmd_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      stageCmd_q <= '0;
    end else begin
      stageCmd_q <= stageCmdIn;
      stageCmd_q.valid <= stageCmdIn.valid && (!locked_q || stageCmdIn.exempt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer window mirror and error counter.

  logic [5:0] mirror_q;
  logic [2:0] errCount_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      mirror_q <= dsr_pkg::RESP_TIME_RESET;
    end else if (answerWindowWrite) begin
      mirror_q <= answerWindowLength;
    end
  end

  // The counter stops at its top value rather than wrapping to a clean count.
  always_ff @(posedge clock) begin
    if (rst) begin
      errCount_q <= dsr_pkg::ERR_COUNT_RESET;
    end else if (answerWindowWrite && errCount_q != dsr_pkg::ERR_COUNT_MAX) begin
      errCount_q <= errCount_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register view and read port.

  logic [7:0] regBridge;
  logic [7:0] regIgnition;
  logic [7:0] regSupply;
  logic [7:0] regResetCause;
  logic [7:0] regOvertemp;
  logic [7:0] regSafety;
  logic [7:0] regRespTime;
  logic [7:0] readMux;

  always_comb begin
    if (status.hbridgeMode) begin
      regBridge = encodeBridge(sticky.bridge);
    end else begin
      regBridge[7:6] = encodeNormal(sticky.bridgeOut[3]);
      regBridge[5:4] = encodeNormal(sticky.bridgeOut[2]);
      regBridge[3:2] = encodeSwapped(sticky.bridgeOut[1]);
      regBridge[1:0] = encodeSwapped(sticky.bridgeOut[0]);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      regIgnition[2*i +: 2] = encodeNormal(sticky.spark[i]);
    end
  end

  always_comb begin
    regSupply[7] = keyHyst_q;
    regSupply[6] = status.relayOvercurrentOff;
    regSupply[5] = status.reluctanceDiagActive;
    regSupply[4] = sticky.reluctanceFault;
    regSupply[3:2] = encodeSupply(sticky.trackOverload[1], sticky.trackOvOt[1]);
    regSupply[1:0] = encodeSupply(sticky.trackOverload[0], sticky.trackOvOt[0]);
  end

  assign regResetCause = {sticky.tunnelReset, sticky.mainSummary,
                          sticky.shortUndervoltageReset, sticky.bridgeSummary,
                          sticky.logicRailOvervoltage, sticky.lowRailUndervoltage,
                          locked_q, sticky.batteryOvervoltageShutoff};

  assign regOvertemp = {sticky.overtemp, sticky.longUndervoltageReset,
                        sticky.transceiverErr, sticky.monitorResetSticky, 1'b0};

  assign regSafety = {1'b0, sticky.monitorResetSticky, sticky.seoInjector,
                      sticky.seoRelay, status.monitorReset, 2'b00, keyFiltered};

  assign regRespTime = {2'b00, mirror_q};

  always_comb begin
    unique case (readReq.sub)
      dsr_pkg::SUB_BRIDGE_TWO: readMux = regBridge;
      dsr_pkg::SUB_IGNITION: readMux = regIgnition;
      dsr_pkg::SUB_SUPPLY: readMux = regSupply;
      dsr_pkg::SUB_RESET_CAUSE: readMux = regResetCause;
      dsr_pkg::SUB_OVERTEMP: readMux = regOvertemp;
      dsr_pkg::SUB_SAFETY: readMux = regSafety;
      dsr_pkg::SUB_RESP_TIME: readMux = regRespTime;
      default: readMux = dsr_pkg::READ_DATA_RESET;
    endcase
  end

  // The answer is taken from the pre-clear view at the request edge, so all
  // eight bits belong to one instant; clearing lands on that same edge.
  dsr_pkg::dsr_read_ans_t readAns_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      readAns_q <= '0;
    end else begin
      readAns_q.valid <= readHit;
      if (readHit) begin
        readAns_q.data <= readMux;
      end
    end
  end

  // Writes to this bank are acknowledged by nobody and alter no content.
  logic writeIgnored;
  assign writeIgnored = writeReq & (|writeSub);

  logic locked_out_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      locked_out_q <= 1'b1;
    end else begin
      locked_out_q <= locked_q | (writeIgnored & 1'b0);
    end
  end

  assign readAns = readAns_q;
  assign stageCmdOut = stageCmd_q;
  assign stagesLockedFlag = locked_out_q;
  assign errorCount = errCount_q;
  assign answerWindowMirror = mirror_q;

endmodule : dsr_bank
`default_nettype wire

// ==== rtl/dsr_pkg.sv ====
/*
  Constants, types and register map of the diagnostic status bank.
  Assumes a serial frame decoder outside that hands over decoded reads.
*/
// Notes on behaviour
// - Upper bridge outputs: ground, open, battery, ok.
// - Lower bridge outputs use swapped short codes.
// - H-bridge mode reports one eight-bit state code.
// - Four spark drivers, two bits each, highest first.
// - Relay overcurrent bit shows driver off state.
// - Reluctance diagnosis active and generic fault bits.
// - Tracking supply codes, overload beats overvoltage.
// - Reset cause flags for tunnel and undervoltage.
// - Summary faults for main and bridge stages.
// - Logic rail overvoltage and low rail undervoltage.
// - Battery overvoltage shutoff flag in bit zero.
// - Locked flag blocks stage commands not marked exempt.
// - Lock survives reads; set by resets.
// - Four overtemperature flags in bits seven to four.
// - Transceiver error when any condition is present.
// - Live and sticky monitor reset flags.
// - Two secure engine off event bits.
// - Reading a register clears its fault bits.
// - Answer window write bumps error counter.
`default_nettype none
package dsr_pkg;

  localparam logic [7:0] SUB_BRIDGE_TWO = 8'h07;
  localparam logic [7:0] SUB_IGNITION = 8'h08;
  localparam logic [7:0] SUB_SUPPLY = 8'h09;
  localparam logic [7:0] SUB_RESET_CAUSE = 8'h0a;
  localparam logic [7:0] SUB_OVERTEMP = 8'h0b;
  localparam logic [7:0] SUB_SAFETY = 8'h0c;
  localparam logic [7:0] SUB_RESP_TIME = 8'h0d;
  localparam logic [2:0] CMD_READ_CLEAR_MON = 3'h5;
  localparam logic [2:0] CMD_READ_LIVE_MON = 3'h7;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [5:0] RESP_TIME_RESET = 6'h3f;
  localparam logic [2:0] ERR_COUNT_RESET = 3'h6;
  localparam logic [2:0] ERR_COUNT_MAX = 3'h7;
  localparam logic [1:0] CODE_SHORT_LOW = 2'h0;
  localparam logic [1:0] CODE_OPEN = 2'h1;
  localparam logic [1:0] CODE_SHORT_HIGH = 2'h2;
  localparam logic [1:0] CODE_OK = 2'h3;
  localparam logic [1:0] SUPPLY_OVERLOAD = 2'h1;
  localparam logic [1:0] SUPPLY_OV_OT = 2'h2;
  localparam logic [7:0] HB_GND_OFF = 8'h01;
  localparam logic [7:0] HB_SUP_OFF = 8'h05;
  localparam logic [7:0] HB_OPEN_OFF = 8'h04;
  localparam logic [7:0] HB_OPEN_ON = 8'h02;
  localparam logic [7:0] HB_OVC_ON = 8'h03;
  localparam logic [7:0] HB_RUNNING = 8'h07;
  localparam logic [7:0] HB_OK = 8'hff;

  typedef struct packed {
    logic toGround;
    logic open;
    logic toSupply;
  } dsr_stage_fault_t;

  typedef struct packed {
    logic gndShortOff;
    logic supShortOff;
    logic openOff;
    logic openOn;
    logic overcurOn;
    logic detectRunning;
  } dsr_bridge_state_t;

  typedef struct packed {
    dsr_stage_fault_t [3:0] bridgeOut;
    dsr_bridge_state_t bridge;
    logic hbridgeMode;
    dsr_stage_fault_t [3:0] spark;
    logic relayOvercurrentOff;
    logic reluctanceDiagActive;
    logic reluctanceFault;
    logic [1:0] trackOverload;
    logic [1:0] trackOvOt;
    logic tunnelReset;
    logic shortUndervoltageReset;
    logic longUndervoltageReset;
    logic mainStageFault;
    logic logicRailOvervoltage;
    logic lowRailUndervoltage;
    logic batteryOvervoltageShutoff;
    logic [3:0] overtemp;
    logic [3:0] transceiverErr;
    logic monitorReset;
    logic seoInjector;
    logic seoRelay;
  } dsr_status_t;

  typedef struct packed {
    dsr_stage_fault_t [3:0] bridgeOut;
    dsr_bridge_state_t bridge;
    dsr_stage_fault_t [3:0] spark;
    logic reluctanceFault;
    logic [1:0] trackOverload;
    logic [1:0] trackOvOt;
    logic tunnelReset;
    logic shortUndervoltageReset;
    logic mainSummary;
    logic bridgeSummary;
    logic logicRailOvervoltage;
    logic lowRailUndervoltage;
    logic batteryOvervoltageShutoff;
    logic [3:0] overtemp;
    logic longUndervoltageReset;
    logic transceiverErr;
    logic monitorResetSticky;
    logic seoInjector;
    logic seoRelay;
  } dsr_sticky_t;

  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [7:0] sub;
  } dsr_read_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dsr_read_ans_t;

  typedef struct packed {
    logic valid;
    logic exempt;
    logic [4:0] addr;
    logic [7:0] data;
  } dsr_stage_cmd_t;

endpackage : dsr_pkg
`default_nettype wire

// ==== rtl/dsr_sticky.sv ====
/*
  Vector of sticky flags; a set in the clearing cycle wins over the clear.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_sticky #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] setIn,
  input wire logic [W-1:0] clrIn,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_q;
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (rst) begin
        flags_q[i] <= 1'b0;
      end else if (setIn[i]) begin
        flags_q[i] <= 1'b1;
      end else if (clrIn[i]) begin
        flags_q[i] <= 1'b0;
      end
    end
  end
  assign flags = flags_q;
endmodule : dsr_sticky
`default_nettype wire

// ==== rtl/dsr_sync.sv ====
/*
  Three-flop input synchroniser; output follows once stages two and three agree.
  Assumes asynchronous inputs and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  genvar i;
  for (i = 0; i < W; i++) begin : g_agree
    always_ff @(posedge clock) begin
      if (rst) begin
        out_q[i] <= INIT[i];
      end else if (s2_q[i] == s3_q[i]) begin
        out_q[i] <= s3_q[i];
      end
    end
  end
  assign dout = out_q;
endmodule : dsr_sync
`default_nettype wire

// ==== tb/dsr_bank_props.sv ====
/*
  Checker for the diagnostic status bank ports.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_bank_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic softwareResetCommand,
  input wire logic startCmd,
  input wire dsr_pkg::dsr_read_req_t readReq,
  input wire logic answerWindowWrite,
  input wire logic [5:0] answerWindowLength,
  input wire dsr_pkg::dsr_stage_cmd_t stageCmdIn,
  input wire dsr_pkg::dsr_read_ans_t readAns,
  input wire dsr_pkg::dsr_stage_cmd_t stageCmdOut,
  input wire logic stagesLockedFlag,
  input wire logic [2:0] errorCount,
  input wire logic [5:0] answerWindowMirror
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence read_s(logic [7:0] s);
    readReq.valid && readReq.sub == s;
  endsequence
  // The internal lock sets one edge on, the flag one edge later still.
  sequence relock_s;
    ##2 stagesLockedFlag;
  endsequence
  answer_timing_a: assert property (readReq.valid |=> readAns.valid)
    else $error("read answer missing");
  answer_idle_a: assert property (!readReq.valid |=> !readAns.valid)
    else $error("read answer without request");
  unmapped_zero_a: assert property ((readReq.valid && (readReq.sub < 8'h07 || readReq.sub > 8'h0d))
    |=> readAns.data == 8'h00) else $error("unmapped read not zero");
  mirror_read_a: assert property (read_s(dsr_pkg::SUB_RESP_TIME)
    |=> readAns.data == {2'b00, $past(answerWindowMirror)}) else $error("mirror read wrong");
  lock_read_a: assert property (read_s(dsr_pkg::SUB_RESET_CAUSE)
    |=> readAns.data[1] == stagesLockedFlag) else $error("lock bit read wrong");
  stage_gate_a: assert property (1'b1 |=> stageCmdOut.valid ==
    ($past(stageCmdIn.valid) && ($past(stageCmdIn.exempt) || !stagesLockedFlag)))
    else $error("stage command gate wrong");
  stage_copy_a: assert property (stageCmdIn.valid
    |=> stageCmdOut[13:0] == $past(stageCmdIn[13:0])) else $error("stage fields not copied");
  sw_lock_a: assert property (softwareResetCommand |-> relock_s)
    else $error("software reset did not lock");
  unlock_cause_a: assert property ($fell(stagesLockedFlag) |-> $past(startCmd, 2))
    else $error("lock cleared without start");
  count_step_a: assert property ((answerWindowWrite && errorCount != 3'h7)
    |=> errorCount == $past(errorCount) + 3'h1) else $error("error count step wrong");
  count_hold_a: assert property (!answerWindowWrite |=> $stable(errorCount))
    else $error("error count moved");
  mirror_load_a: assert property (answerWindowWrite
    |=> answerWindowMirror == $past(answerWindowLength)) else $error("mirror not loaded");
endmodule : dsr_bank_props
bind dsr_bank dsr_bank_props props_u (.clock(clock), .rst(rst),
  .softwareResetCommand(softwareResetCommand), .startCmd(startCmd), .readReq(readReq),
  .answerWindowWrite(answerWindowWrite), .answerWindowLength(answerWindowLength),
  .stageCmdIn(stageCmdIn), .readAns(readAns), .stageCmdOut(stageCmdOut),
  .stagesLockedFlag(stagesLockedFlag), .errorCount(errorCount),
  .answerWindowMirror(answerWindowMirror));
`default_nettype wire

// ==== tb/dsr_host_model.sv ====
/*
  Host side: issues reads and lock commands.
  Assumes callers step just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dsr_host_model (
  input wire logic clock,
  output dsr_pkg::dsr_read_req_t readReq,
  output logic startCmd,
  output logic softwareResetCommand
);
  initial begin
    readReq = '0;
    startCmd = 1'b0;
    softwareResetCommand = 1'b0;
  end
  // Released fields are inverted so a stale value cannot pass.
  task automatic read(input logic [2:0] c, input logic [7:0] s);
    readReq = {1'b1, c, s};
    @(posedge clock);
    #1;
    readReq = {1'b0, ~c, ~s};
  endtask : read
  task automatic start;
    startCmd = 1'b1;
    @(posedge clock);
    #1;
    startCmd = 1'b0;
  endtask : start
  task automatic swReset;
    softwareResetCommand = 1'b1;
    @(posedge clock);
    #1;
    softwareResetCommand = 1'b0;
  endtask : swReset
endmodule : dsr_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the diagnostic status bank.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst, keyPin, keyAboveHigh, keyBelowLow, resetPinN;
  logic writeReq, answerWindowWrite, stagesLockedFlag, softwareResetCommand, startCmd;
  logic [7:0] writeSub;
  logic [5:0] answerWindowLength, answerWindowMirror;
  logic [2:0] errorCount;
  dsr_pkg::dsr_status_t status;
  dsr_pkg::dsr_read_req_t readReq;
  dsr_pkg::dsr_read_ans_t readAns;
  dsr_pkg::dsr_stage_cmd_t stageCmdIn, stageCmdOut;
  logic [7:0] expQ[$];
  logic [7:0] hb[6] = '{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07};
  int errCount = 0;
  int totalChecks = 0;
  dsr_bank dut_u (.clock(clock), .rst(rst), .status(status), .keyPin(keyPin),
    .keyAboveHigh(keyAboveHigh), .keyBelowLow(keyBelowLow), .resetPinN(resetPinN),
    .softwareResetCommand(softwareResetCommand), .startCmd(startCmd), .readReq(readReq),
    .writeReq(writeReq), .writeSub(writeSub), .answerWindowWrite(answerWindowWrite),
    .answerWindowLength(answerWindowLength), .stageCmdIn(stageCmdIn), .readAns(readAns),
    .stageCmdOut(stageCmdOut), .stagesLockedFlag(stagesLockedFlag),
    .errorCount(errorCount), .answerWindowMirror(answerWindowMirror));
  dsr_host_model host_u (.clock(clock), .readReq(readReq), .startCmd(startCmd),
    .softwareResetCommand(softwareResetCommand));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (errCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  task automatic rd(input logic [2:0] c, input logic [7:0] s, input logic [7:0] e);
    expQ.push_back(e);
    host_u.read(c, s);
    tick;
  endtask : rd
  task automatic stage(input logic ex, input logic ev);
    logic [7:0] d;
    d = 8'($urandom);
    stageCmdIn = {1'b1, ex, 5'($urandom), d};
    tick;
    chk({7'h00, stageCmdOut.valid}, {7'h00, ev}, "stageValid");
    if (ev) chk(stageCmdOut.data, d, "stageData");
    stageCmdIn.valid = 1'b0;
    tick;
  endtask : stage
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // The answer is read mid-cycle, where it has long settled.
  always @(negedge clock) begin
    if (readAns.valid === 1'b1) begin
      if (expQ.size() > 0) chk(readAns.data, expQ.pop_front(), "readAns");
      else chk(8'h00, 8'h01, "spuriousAnswer");
    end
  end
  initial begin
    repeat (5000) @(posedge clock);
    errCount++;
    conclude();
  end
  initial begin
    void'($urandom(32'hca0a5c91));
    {rst, keyPin, keyAboveHigh, keyBelowLow, writeReq, answerWindowWrite} = 6'h20;
    {resetPinN, writeSub, answerWindowLength} = {1'b1, 14'h0000};
    status = '0;
    stageCmdIn = '0;
    repeat (3) tick;
    rst = 1'b0;
    {keyPin, keyAboveHigh} = 2'h3;
    repeat (4) tick;
    chk({7'h00, stagesLockedFlag}, 8'h01, "lockAtReset");
    chk({5'h00, errorCount}, 8'h06, "countAtReset");
    chk({2'h0, answerWindowMirror}, 8'h3f, "mirrorAtReset");
    rd(3'h0, dsr_pkg::SUB_RESET_CAUSE, 8'h02);
    stage(1'b0, 1'b0);
    stage(1'b1, 1'b1);
    host_u.start();
    stage(1'b0, 1'b1);
    rd(3'h0, dsr_pkg::SUB_RESET_CAUSE, 8'h00);
    {writeReq, writeSub} = {1'b1, 8'h07 + 8'($urandom_range(6))};
    tick;
    writeReq = 1'b0;
    rd(3'h0, 8'h20, 8'h00);
    host_u.swReset();
    repeat (2) tick;
    chk({7'h00, stagesLockedFlag}, 8'h01, "lockAfterSw");
    host_u.start();
    resetPinN = 1'b0;
    repeat (6) tick;
    resetPinN = 1'b1;
    repeat (6) tick;
    chk({7'h00, stagesLockedFlag}, 8'h01, "lockAfterPin");
    host_u.start();
    {status.tunnelReset, status.mainStageFault, status.logicRailOvervoltage} = 3'h7;
    {status.batteryOvervoltageShutoff, status.spark[3].toGround, status.spark[2].open} = 3'h7;
    status.spark[1].toSupply = 1'b1;
    tick;
    status = '0;
    rd(3'h0, dsr_pkg::SUB_RESET_CAUSE, 8'hc9);
    rd(3'h0, dsr_pkg::SUB_IGNITION, 8'h1b);
    rd(3'h0, dsr_pkg::SUB_RESET_CAUSE, 8'h00);
    {status.shortUndervoltageReset, status.lowRailUndervoltage} = 2'h3;
    {status.bridgeOut[3].toGround, status.bridgeOut[2].toSupply} = 2'h3;
    {status.bridgeOut[1].toGround, status.bridgeOut[0].toSupply} = 2'h3;
    tick;
    status = '0;
    rd(3'h0, dsr_pkg::SUB_RESET_CAUSE, 8'h34);
    rd(3'h0, dsr_pkg::SUB_BRIDGE_TWO, 8'h28);
    rd(3'h0, dsr_pkg::SUB_BRIDGE_TWO, 8'hff);
    foreach (hb[i]) begin
      status.hbridgeMode = 1'b1;
      status.bridge = 6'h20 >> i;
      tick;
      status.bridge = '0;
      rd(3'h0, dsr_pkg::SUB_BRIDGE_TWO, hb[i]);
    end
    rd(3'h0, dsr_pkg::SUB_BRIDGE_TWO, dsr_pkg::HB_OK);
    status = '0;
    {status.relayOvercurrentOff, status.reluctanceDiagActive, status.reluctanceFault} = 3'h7;
    {status.trackOverload, status.trackOvOt} = 4'h7;
    tick;
    {status.reluctanceFault, status.trackOverload, status.trackOvOt} = 5'h00;
    rd(3'h0, dsr_pkg::SUB_SUPPLY, 8'hf9);
    status = '0;
    {keyAboveHigh, keyBelowLow} = 2'h1;
    repeat (5) tick;
    rd(3'h0, dsr_pkg::SUB_SUPPLY, 8'h0f);
    {status.overtemp, status.transceiverErr, status.longUndervoltageReset} = 9'h145;
    {status.monitorReset, status.seoInjector, status.seoRelay} = 3'h7;
    tick;
    status = '0;
    rd(3'h7, dsr_pkg::SUB_OVERTEMP, 8'hae);
    rd(3'h7, dsr_pkg::SUB_SAFETY, 8'h71);
    rd(3'h5, dsr_pkg::SUB_SAFETY, 8'h41);
    rd(3'h0, dsr_pkg::SUB_OVERTEMP, 8'h00);
    for (int k = 0; k < 2; k++) begin
      answerWindowLength = 6'($urandom);
      answerWindowWrite = 1'b1;
      tick;
      chk({2'h0, answerWindowMirror}, {2'h0, answerWindowLength}, "mirror");
      chk({5'h00, errorCount}, 8'h07, "errorCount");
    end
    answerWindowWrite = 1'b0;
    rd(3'h0, dsr_pkg::SUB_RESP_TIME, {2'h0, answerWindowLength});
    repeat (3) tick;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
